/* rtl/gpl_port.sv */
// Purpose: register logic of one 16-pin port with keyed configuration lock
// Assumes: AXI4-Lite slave, one write and one read under way at a time
// Notes: pad inputs are synchronous to clock and sampled once
//
// Summary of operation
// - each pin has one bit: 0 push-pull, 1 open-drain output stage
// - each pin has a 2-bit drive code: 4, 8, 12 or 16 mA
// - lock write counts only when key half equals 0x5fa0, else discarded
// - key half reads back lock status: 0 unlocked, 1 locked
// - lower lock half holds one lock bit per pin, set with key
// - locked pin freezes direction, input enable, pulls and open-drain
// - locked pin also freezes its alternate-function selection field
// - lock register accepts one successful write until system or port reset
// - input-level register is read-only, one sampled level per pin
// - disabled input function forces that pin's input-level bit to 0
//
// Decided for this implementation: register access over AXI4-Lite.
`include "gpl_defines.svh"

module gpl_port #(
   parameter int ADDR_W = `GPL_ADDR_W
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic port_rst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] pin_in,
   output logic [15:0] pin_direction_bit,
   output logic [15:0] pin_input_enable_bit,
   output logic [15:0] pin_pullup_bit,
   output logic [15:0] pin_pulldown_bit,
   output logic [15:0] pin_open_drain_bit,
   output logic [31:0] pin_drive_code,
   output logic [31:0] altfunc_select_low,
   output logic [31:0] altfunc_select_high,
   output logic [15:0] pin_lock_bit,
   output logic port_locked
);

   // byte lanes to a bit mask
   function automatic gpl_pkg::gpl_word_type lane_mask(
      input logic [3:0] strb
   );
      lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction

   // keep frozen bits, take written lanes elsewhere
   function automatic gpl_pkg::gpl_word_type merge_word(
      input gpl_pkg::gpl_word_type old_word,
      input gpl_pkg::gpl_word_type new_word,
      input gpl_pkg::gpl_word_type wr_mask,
      input gpl_pkg::gpl_word_type frozen
   );
      gpl_pkg::gpl_word_type take;
      take = wr_mask & ~frozen;
      merge_word = (old_word & ~take) | (new_word & take);
   endfunction

   // spread eight lock bits over eight 4-bit fields
   function automatic gpl_pkg::gpl_word_type alt_frozen(
      input logic [7:0] locks
   );
      alt_frozen = `GPL_RESET_WORD;
      for (int i = 0; i < `GPL_ALT_PINS_PER_WORD; i++) begin
         alt_frozen[i*`GPL_ALT_FIELD_W +: `GPL_ALT_FIELD_W] = {4{locks[i]}};
      end
   endfunction

   function automatic logic addr_hit(
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] offset
   );
      addr_hit = ({addr[ADDR_W-1:2], 2'b00} == offset);
   endfunction

   // write channel state
   gpl_pkg::gpl_wr_state_type wr_state_reg;
   logic aw_hold_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic w_hold_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic [1:0] bresp_reg;
   logic write_fire;
   gpl_pkg::gpl_word_type wmask;

   // read channel state
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rd_word;
   logic rd_ok;

   // configuration words
   logic [15:0] direction_reg;
   logic [15:0] input_enable_reg;
   logic [15:0] pullup_reg;
   logic [15:0] pulldown_reg;
   logic [15:0] open_drain_reg;
   logic [31:0] drive_reg;
   logic [31:0] alt_low_reg;
   logic [31:0] alt_high_reg;
   logic [15:0] input_level_reg;

   logic [15:0] lock_bits;
   logic locked;
   gpl_pkg::gpl_word_type frozen16;
   logic lock_wr;
   logic port_clear;
   logic wr_mapped;

   assign port_clear = srst || port_rst;
   assign frozen16 = {16'h0000, lock_bits};
   assign wmask = lane_mask(w_strb_reg);

   // a write is done once both halves are held and no answer is pending
   assign write_fire = (wr_state_reg == gpl_pkg::GPL_WR_COLLECT) &&
      aw_hold_reg && w_hold_reg;

   assign s_axi_awready = (wr_state_reg == gpl_pkg::GPL_WR_COLLECT) &&
      !aw_hold_reg;
   assign s_axi_wready = (wr_state_reg == gpl_pkg::GPL_WR_COLLECT) &&
      !w_hold_reg;
   assign s_axi_bvalid = (wr_state_reg == gpl_pkg::GPL_WR_RESP);
   assign s_axi_bresp = bresp_reg;

   always_comb begin
      if (addr_hit(aw_addr_reg, `GPL_OFF_DIRECTION)) begin
         wr_mapped = 1'b1;
      end else if (addr_hit(aw_addr_reg, `GPL_OFF_INPUT_ENABLE)) begin
         wr_mapped = 1'b1;
      end else if (addr_hit(aw_addr_reg, `GPL_OFF_PULLUP)) begin
         wr_mapped = 1'b1;
      end else if (addr_hit(aw_addr_reg, `GPL_OFF_PULLDOWN)) begin
         wr_mapped = 1'b1;
      end else if (addr_hit(aw_addr_reg, `GPL_OFF_OPEN_DRAIN)) begin
         wr_mapped = 1'b1;
      end else if (addr_hit(aw_addr_reg, `GPL_OFF_DRIVE)) begin
         wr_mapped = 1'b1;
      end else if (addr_hit(aw_addr_reg, `GPL_OFF_LOCK)) begin
         wr_mapped = 1'b1;
      end else if (addr_hit(aw_addr_reg, `GPL_OFF_INPUT_LEVEL)) begin
         wr_mapped = 1'b1;
      end else if (addr_hit(aw_addr_reg, `GPL_OFF_ALTFUNC_LOW)) begin
         wr_mapped = 1'b1;
      end else if (addr_hit(aw_addr_reg, `GPL_OFF_ALTFUNC_HIGH)) begin
         wr_mapped = 1'b1;
      end else begin
         wr_mapped = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         wr_state_reg <= gpl_pkg::GPL_WR_COLLECT;
         bresp_reg <= `GPL_RESP_OKAY;
      end else begin
         case (wr_state_reg)
            gpl_pkg::GPL_WR_COLLECT: begin
               if (write_fire) begin
                  wr_state_reg <= gpl_pkg::GPL_WR_RESP;
                  // frozen bits and a refused key still answer okay
                  bresp_reg <= wr_mapped ? `GPL_RESP_OKAY :
                     `GPL_RESP_SLVERR;
               end
            end
            gpl_pkg::GPL_WR_RESP: begin
               if (s_axi_bready) begin
                  wr_state_reg <= gpl_pkg::GPL_WR_COLLECT;
               end
            end
            default: begin
               wr_state_reg <= gpl_pkg::GPL_WR_COLLECT;
            end
         endcase
      end
   end

   // address and data are taken in either order and held until the write
   always_ff @(posedge clock) begin
      if (srst) begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (write_fire) begin
         aw_hold_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         w_hold_reg <= 1'b0;
         w_data_reg <= `GPL_RESET_WORD;
         w_strb_reg <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end else if (write_fire) begin
         w_hold_reg <= 1'b0;
      end
   end

   // pin configuration words; a port reset clears them as well
   always_ff @(posedge clock) begin
      if (port_clear) begin
         direction_reg <= `GPL_RESET_HALF;
         input_enable_reg <= `GPL_RESET_HALF;
         pullup_reg <= `GPL_RESET_HALF;
         pulldown_reg <= `GPL_RESET_HALF;
         open_drain_reg <= `GPL_RESET_HALF;
      end else if (write_fire) begin
         if (addr_hit(aw_addr_reg, `GPL_OFF_DIRECTION)) begin
            direction_reg <= 16'(merge_word({16'h0000, direction_reg},
               w_data_reg, wmask, frozen16));
         end else if (addr_hit(aw_addr_reg, `GPL_OFF_INPUT_ENABLE)) begin
            input_enable_reg <= 16'(merge_word({16'h0000,
               input_enable_reg}, w_data_reg, wmask,
               frozen16));
         end else if (addr_hit(aw_addr_reg, `GPL_OFF_PULLUP)) begin
            pullup_reg <= 16'(merge_word({16'h0000, pullup_reg},
               w_data_reg, wmask, frozen16));
         end else if (addr_hit(aw_addr_reg, `GPL_OFF_PULLDOWN)) begin
            pulldown_reg <= 16'(merge_word({16'h0000, pulldown_reg},
               w_data_reg, wmask, frozen16));
         end else if (addr_hit(aw_addr_reg, `GPL_OFF_OPEN_DRAIN)) begin
            open_drain_reg <= 16'(merge_word({16'h0000, open_drain_reg},
               w_data_reg, wmask, frozen16));
         end
      end
   end

   // drive strength is not among the locked settings
   always_ff @(posedge clock) begin
      if (port_clear) begin
         drive_reg <= `GPL_RESET_WORD;
      end else if (write_fire && addr_hit(aw_addr_reg, `GPL_OFF_DRIVE)) begin
         drive_reg <= merge_word(drive_reg, w_data_reg, wmask,
            `GPL_RESET_WORD);
      end
   end

   always_ff @(posedge clock) begin
      if (port_clear) begin
         alt_low_reg <= `GPL_RESET_WORD;
         alt_high_reg <= `GPL_RESET_WORD;
      end else if (write_fire) begin
         if (addr_hit(aw_addr_reg, `GPL_OFF_ALTFUNC_LOW)) begin
            alt_low_reg <= merge_word(alt_low_reg, w_data_reg, wmask,
               alt_frozen(lock_bits[7:0]));
         end else if (addr_hit(aw_addr_reg, `GPL_OFF_ALTFUNC_HIGH)) begin
            alt_high_reg <= merge_word(alt_high_reg, w_data_reg, wmask,
               alt_frozen(lock_bits[15:8]));
         end
      end
   end

   // one sampling stage; a disabled input reads low whatever the pad does
   always_ff @(posedge clock) begin
      if (port_clear) begin
         input_level_reg <= `GPL_RESET_HALF;
      end else begin
         input_level_reg <= pin_in & input_enable_reg;
      end
   end

   assign lock_wr = write_fire && addr_hit(aw_addr_reg, `GPL_OFF_LOCK);

   gpl_lock_unit u_lock (
      .clock(clock),
      .srst(srst),
      .port_rst(port_rst),
      .wr_en(lock_wr),
      .wdata(w_data_reg),
      .wstrb(w_strb_reg),
      .lock_bits(lock_bits),
      .port_locked(locked)
   );

   // read decode
   always_comb begin
      rd_ok = 1'b1;
      if (addr_hit(s_axi_araddr, `GPL_OFF_DIRECTION)) begin
         rd_word = {16'h0000, direction_reg};
      end else if (addr_hit(s_axi_araddr, `GPL_OFF_INPUT_ENABLE)) begin
         rd_word = {16'h0000, input_enable_reg};
      end else if (addr_hit(s_axi_araddr, `GPL_OFF_PULLUP)) begin
         rd_word = {16'h0000, pullup_reg};
      end else if (addr_hit(s_axi_araddr, `GPL_OFF_PULLDOWN)) begin
         rd_word = {16'h0000, pulldown_reg};
      end else if (addr_hit(s_axi_araddr, `GPL_OFF_OPEN_DRAIN)) begin
         rd_word = {16'h0000, open_drain_reg};
      end else if (addr_hit(s_axi_araddr, `GPL_OFF_DRIVE)) begin
         rd_word = drive_reg;
      end else if (addr_hit(s_axi_araddr, `GPL_OFF_LOCK)) begin
         rd_word = {15'h0000, locked, lock_bits};
      end else if (addr_hit(s_axi_araddr, `GPL_OFF_INPUT_LEVEL)) begin
         rd_word = {16'h0000, input_level_reg};
      end else if (addr_hit(s_axi_araddr, `GPL_OFF_ALTFUNC_LOW)) begin
         rd_word = alt_low_reg;
      end else if (addr_hit(s_axi_araddr, `GPL_OFF_ALTFUNC_HIGH)) begin
         rd_word = alt_high_reg;
      end else begin
         rd_word = `GPL_RESET_WORD;
         rd_ok = 1'b0;
      end
   end

   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   always_ff @(posedge clock) begin
      if (srst) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= `GPL_RESET_WORD;
         rresp_reg <= `GPL_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_word;
         rresp_reg <= rd_ok ? `GPL_RESP_OKAY : `GPL_RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign pin_direction_bit = direction_reg;
   assign pin_input_enable_bit = input_enable_reg;
   assign pin_pullup_bit = pullup_reg;
   // pull-up wins when both are set, so the pad never fights itself
   assign pin_pulldown_bit = pulldown_reg & ~pullup_reg;
   assign pin_open_drain_bit = open_drain_reg;
   assign pin_drive_code = drive_reg;
   assign altfunc_select_low = alt_low_reg;
   assign altfunc_select_high = alt_high_reg;
   assign pin_lock_bit = lock_bits;
   assign port_locked = locked;

endmodule

/* common/gpl_defines.svh */
// Purpose: offsets, field layout, reset values and key of the pin port
// Assumes: 32-bit register words, byte addresses within a 12-bit window
// Notes: altfunc words hold a 4-bit selection field per pin
`ifndef GPL_DEFINES_SVH
`define GPL_DEFINES_SVH

`define GPL_ADDR_W 12
`define GPL_OFF_DIRECTION 12'h000
`define GPL_OFF_INPUT_ENABLE 12'h004
`define GPL_OFF_PULLUP 12'h008
`define GPL_OFF_PULLDOWN 12'h00c
`define GPL_OFF_OPEN_DRAIN 12'h010
`define GPL_OFF_DRIVE 12'h014
`define GPL_OFF_LOCK 12'h018
`define GPL_OFF_INPUT_LEVEL 12'h01c
`define GPL_OFF_ALTFUNC_LOW 12'h040
`define GPL_OFF_ALTFUNC_HIGH 12'h044

`define GPL_NUM_PINS 16
`define GPL_LOCK_KEY 16'h5fa0
`define GPL_KEY_MSB 31
`define GPL_KEY_LSB 16
`define GPL_PINS_MSB 15
`define GPL_ALT_FIELD_W 4
`define GPL_ALT_PINS_PER_WORD 8

`define GPL_RESET_WORD 32'h00000000
`define GPL_RESET_HALF 16'h0000

`define GPL_RESP_OKAY 2'b00
`define GPL_RESP_SLVERR 2'b10

`endif

/* common/gpl_pkg.sv */
// Purpose: shared types of the pin port
// Assumes: nothing beyond the defines header
// Notes: state codes are one-hot
package gpl_pkg;

   typedef enum logic [1:0] {
      GPL_WR_COLLECT = 2'b01,
      GPL_WR_RESP = 2'b10
   } gpl_wr_state_type;

   typedef logic [31:0] gpl_word_type;

endpackage

/* rtl/gpl_lock_unit.sv */
// Purpose: keyed write-once lock over per-pin configuration
// Assumes: wr_en is a one-cycle pulse of a bus write to the lock word
// Notes: only srst or port_rst reopen the lock
`include "gpl_defines.svh"

module gpl_lock_unit (
   input wire logic clock,
   input wire logic srst,
   input wire logic port_rst,
   input wire logic wr_en,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic [15:0] lock_bits,
   output logic port_locked
);

   logic locked_reg;
   logic [15:0] lock_reg;
   logic key_ok;
   logic [15:0] lane_mask;

   // the key must arrive whole; a partial key lane is as bad as a wrong key
   assign key_ok = (wstrb[3:2] == 2'b11) &&
      (wdata[`GPL_KEY_MSB:`GPL_KEY_LSB] == `GPL_LOCK_KEY);
   assign lane_mask = {{8{wstrb[1]}}, {8{wstrb[0]}}};

   always_ff @(posedge clock) begin
      if (srst || port_rst) begin
         locked_reg <= 1'b0;
         lock_reg <= `GPL_RESET_HALF;
      end else if (wr_en && key_ok && !locked_reg) begin
         locked_reg <= 1'b1;
         lock_reg <= wdata[`GPL_PINS_MSB:0] & lane_mask;
      end
   end

   assign lock_bits = lock_reg;
   assign port_locked = locked_reg;

endmodule

/* sim/gpl_port_sva.sv */
// Purpose: bus timing and lock freezing checks at the port boundary
// Assumes: the master offers write address and data in the same cycle
// Notes: bound from the bench top file
`include "gpl_defines.svh"

module gpl_port_sva #(
   parameter int ADDR_W = `GPL_ADDR_W
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic port_rst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] pin_direction_bit,
   input wire logic [15:0] pin_input_enable_bit,
   input wire logic [15:0] pin_pullup_bit,
   input wire logic [15:0] pin_pulldown_bit,
   input wire logic [15:0] pin_open_drain_bit,
   input wire logic [31:0] altfunc_select_low,
   input wire logic [31:0] altfunc_select_high,
   input wire logic [15:0] pin_lock_bit,
   input wire logic port_locked
);
   logic [31:0] alt_mask_low;
   logic [31:0] alt_mask_high;
   logic wr_both;
   logic lock_wr;

   for (genvar i = 0; i < 8; i++) begin : g_mask
      assign alt_mask_low[4*i+:4] = {4{pin_lock_bit[i]}};
      assign alt_mask_high[4*i+:4] = {4{pin_lock_bit[i+8]}};
   end
   assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready;
   // only an unlocked port can take a lock word
   assign lock_wr = wr_both && !port_locked
      && s_axi_awaddr == ADDR_W'(`GPL_OFF_LOCK);

   default clocking @(posedge clock);
   endclocking
   default disable iff (srst);

   write_answer_a: assert property (wr_both |-> ##2 s_axi_bvalid)
      else $error("write answer missing");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer missing");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped early");
   bad_key_a: assert property (
      lock_wr && s_axi_wdata[31:16] != `GPL_LOCK_KEY |-> ##2 !port_locked)
      else $error("lock taken with wrong key");
   lock_take_a: assert property (
      disable iff (srst || port_rst)
      lock_wr && s_axi_wdata[31:16] == `GPL_LOCK_KEY && s_axi_wstrb == 4'hf
      |-> ##2 port_locked && pin_lock_bit == $past(s_axi_wdata[15:0], 2))
      else $error("keyed lock word not taken");
   lock_once_a: assert property (port_locked && !port_rst
      |=> port_locked && $stable(pin_lock_bit))
      else $error("lock changed without reset");
   unlocked_clear_a: assert property (
      !port_locked |-> pin_lock_bit == 16'h0000)
      else $error("lock bits set while unlocked");
   pin_freeze_a: assert property (!port_rst |=>
      (((pin_direction_bit ^ $past(pin_direction_bit))
      | (pin_input_enable_bit ^ $past(pin_input_enable_bit))
      | (pin_pullup_bit ^ $past(pin_pullup_bit))
      | (pin_pulldown_bit ^ $past(pin_pulldown_bit))
      | (pin_open_drain_bit ^ $past(pin_open_drain_bit)))
      & $past(pin_lock_bit)) == 16'h0000)
      else $error("locked pin setting changed");
   alt_freeze_a: assert property (!port_rst |=>
      (((altfunc_select_low ^ $past(altfunc_select_low))
      & $past(alt_mask_low)) | ((altfunc_select_high
      ^ $past(altfunc_select_high)) & $past(alt_mask_high))) == 32'h0)
      else $error("locked function field changed");
endmodule

/* sim/gpl_port_test.sv */
// Purpose: register-level test of the pin port with keyed lock
// Assumes: AXI4-Lite answers as described for the port
// Notes: expectations are worked out here, never read from the design
`include "gpl_defines.svh"

module gpl_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic port_rst = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic [11:0] s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic [15:0] pin_in = 16'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, port_locked;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, pin_drive_code;
   logic [31:0] altfunc_select_low, altfunc_select_high;
   logic [15:0] pin_direction_bit, pin_input_enable_bit, pin_pullup_bit;
   logic [15:0] pin_pulldown_bit, pin_open_drain_bit, pin_lock_bit;
   logic [11:0] offs [10] = '{`GPL_OFF_DIRECTION, `GPL_OFF_INPUT_ENABLE,
      `GPL_OFF_PULLUP, `GPL_OFF_PULLDOWN, `GPL_OFF_OPEN_DRAIN,
      `GPL_OFF_DRIVE, `GPL_OFF_LOCK, `GPL_OFF_INPUT_LEVEL,
      `GPL_OFF_ALTFUNC_LOW, `GPL_OFF_ALTFUNC_HIGH};
   int err_count = 0;
   int checks = 0;
   int cycles = 0;

   gpl_port dut_u (.clock, .srst, .port_rst, .s_axi_awaddr,
      .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_direction_bit,
      .pin_input_enable_bit, .pin_pullup_bit, .pin_pulldown_bit,
      .pin_open_drain_bit, .pin_drive_code, .altfunc_select_low,
      .altfunc_select_high, .pin_lock_bit, .port_locked);

   always #4 clock = ~clock;

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // a run of this length means a handshake never came
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count = err_count + 1;
         complete_run();
      end
   end

   task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         err_count = err_count + 1;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // readies are looked at on the falling edge, taken at the next rise
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic [1:0] er);
      logic aw_p, w_p, b_p, aw_t, w_t, b_t;
      logic [1:0] r;
      @(posedge clock);
      aw_p = 1'b1;
      w_p = 1'b1;
      b_p = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (b_p) begin
         @(negedge clock);
         aw_t = aw_p && s_axi_awready;
         w_t = w_p && s_axi_wready;
         b_t = !aw_p && !w_p && s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clock);
         if (aw_t) begin
            s_axi_awvalid <= 1'b0;
            aw_p = 1'b0;
         end
         if (w_t) begin
            s_axi_wvalid <= 1'b0;
            w_p = 1'b0;
         end
         if (b_t) begin
            s_axi_bready <= 1'b0;
            b_p = 1'b0;
         end
      end
      check_val({30'h0, r}, {30'h0, er});
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp,
      input logic [1:0] er);
      logic ar_p, r_p, ar_t, r_t;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge clock);
      ar_p = 1'b1;
      r_p = 1'b1;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (r_p) begin
         @(negedge clock);
         ar_t = ar_p && s_axi_arready;
         r_t = !ar_p && s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clock);
         if (ar_t) begin
            s_axi_arvalid <= 1'b0;
            ar_p = 1'b0;
         end
         if (r_t) begin
            s_axi_rready <= 1'b0;
            r_p = 1'b0;
         end
      end
      check_val(d, exp);
      check_val({30'h0, r}, {30'h0, er});
   endtask

   initial begin
      repeat (5) @(posedge clock);
      srst <= 1'b0;
      foreach (offs[i]) rd(offs[i], 32'h0, 2'b00);
      $display("test reset values done");
      wr(`GPL_OFF_DRIVE, 32'he4e41b1b, 4'hf, 2'b00);
      rd(`GPL_OFF_DRIVE, 32'he4e41b1b, 2'b00);
      check_val(pin_drive_code, 32'he4e41b1b);
      wr(`GPL_OFF_OPEN_DRAIN, 32'h0000a5c3, 4'hf, 2'b00);
      check_val({16'h0, pin_open_drain_bit}, 32'h0000a5c3);
      wr(`GPL_OFF_OPEN_DRAIN, 32'h0000ff00, 4'h1, 2'b00);
      rd(`GPL_OFF_OPEN_DRAIN, 32'h0000a500, 2'b00);
      $display("test pad settings done");
      pin_in <= 16'h3c3c;
      wr(`GPL_OFF_INPUT_ENABLE, 32'h000000ff, 4'hf, 2'b00);
      check_val({16'h0, pin_input_enable_bit}, 32'h000000ff);
      rd(`GPL_OFF_INPUT_LEVEL, 32'h0000003c, 2'b00);
      wr(`GPL_OFF_INPUT_LEVEL, 32'h0000ffff, 4'hf, 2'b00);
      rd(`GPL_OFF_INPUT_LEVEL, 32'h0000003c, 2'b00);
      wr(12'h0f0, 32'h1, 4'hf, 2'b10);
      rd(12'h0f0, 32'h0, 2'b10);
      // pull-up wins where both pulls are asked for
      wr(`GPL_OFF_PULLUP, 32'h000000ff, 4'hf, 2'b00);
      wr(`GPL_OFF_PULLDOWN, 32'h00000ff0, 4'hf, 2'b00);
      check_val({16'h0, pin_pullup_bit}, 32'h000000ff);
      check_val({16'h0, pin_pulldown_bit}, 32'h00000f00);
      $display("test input level done");
      wr(`GPL_OFF_LOCK, 32'h123400ff, 4'hf, 2'b00);
      rd(`GPL_OFF_LOCK, 32'h0, 2'b00);
      wr(`GPL_OFF_LOCK, 32'h5fa000ff, 4'h3, 2'b00);
      rd(`GPL_OFF_LOCK, 32'h0, 2'b00);
      wr(`GPL_OFF_DIRECTION, 32'h000000f0, 4'hf, 2'b00);
      wr(`GPL_OFF_OPEN_DRAIN, 32'h00000f0f, 4'hf, 2'b00);
      wr(`GPL_OFF_ALTFUNC_LOW, 32'h12345678, 4'hf, 2'b00);
      wr(`GPL_OFF_LOCK, 32'h5fa0000f, 4'hf, 2'b00);
      rd(`GPL_OFF_LOCK, 32'h0001000f, 2'b00);
      check_val({31'h0, port_locked}, 32'h1);
      check_val({16'h0, pin_lock_bit}, 32'h0000000f);
      wr(`GPL_OFF_DIRECTION, 32'h00000f0f, 4'hf, 2'b00);
      rd(`GPL_OFF_DIRECTION, 32'h00000f00, 2'b00);
      check_val({16'h0, pin_direction_bit}, 32'h00000f00);
      wr(`GPL_OFF_PULLUP, 32'h00000000, 4'hf, 2'b00);
      check_val({16'h0, pin_pullup_bit}, 32'h0000000f);
      wr(`GPL_OFF_OPEN_DRAIN, 32'h000000f0, 4'hf, 2'b00);
      rd(`GPL_OFF_OPEN_DRAIN, 32'h000000ff, 2'b00);
      wr(`GPL_OFF_ALTFUNC_LOW, 32'hffffffff, 4'hf, 2'b00);
      rd(`GPL_OFF_ALTFUNC_LOW, 32'hffff5678, 2'b00);
      wr(`GPL_OFF_ALTFUNC_HIGH, 32'h87654321, 4'hf, 2'b00);
      check_val(altfunc_select_high, 32'h87654321);
      wr(`GPL_OFF_LOCK, 32'h5fa0ffff, 4'hf, 2'b00);
      rd(`GPL_OFF_LOCK, 32'h0001000f, 2'b00);
      $display("test lock done");
      port_rst <= 1'b1;
      repeat (2) @(posedge clock);
      port_rst <= 1'b0;
      rd(`GPL_OFF_LOCK, 32'h0, 2'b00);
      wr(`GPL_OFF_LOCK, 32'h5fa00000, 4'hf, 2'b00);
      rd(`GPL_OFF_LOCK, 32'h00010000, 2'b00);
      wr(`GPL_OFF_DIRECTION, 32'h0000ffff, 4'hf, 2'b00);
      rd(`GPL_OFF_DIRECTION, 32'h0000ffff, 2'b00);
      srst <= 1'b1;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      rd(`GPL_OFF_LOCK, 32'h0, 2'b00);
      $display("test lock release done");
      complete_run();
   end
endmodule

bind gpl_port gpl_port_sva #(.ADDR_W(ADDR_W)) sva_u (.clock, .srst,
   .port_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
   .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .pin_direction_bit, .pin_input_enable_bit,
   .pin_pullup_bit, .pin_pulldown_bit, .pin_open_drain_bit,
   .altfunc_select_low, .altfunc_select_high, .pin_lock_bit, .port_locked);
